// ---- pkg/scerr_pkg.sv ----
package scerr_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int AXI_AW = 8; // byte address width of the slave
	localparam int AXI_DW = 32; // data width
	localparam logic [1:0] RESP_OKAY = 2'h0; // normal answer
	localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

	// ------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [AXI_AW-1:0] OFF_STATUS = 8'h00; // host_interrupt_status
	localparam logic [AXI_AW-1:0] OFF_MASK = 8'h04; // interrupt mask, same layout
	localparam logic [AXI_AW-1:0] OFF_CMD = 8'h08; // host_command_reg
	localparam logic [AXI_AW-1:0] OFF_RESP = 8'h0C; // last response word, read only

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int ERR_FLAGS = 3; // command error flags held here
	localparam int BIT_CTO = 16; // resp_timeout_err, lowest flag
	localparam int BIT_RESP_CRC_ERR = 17; // resp_crc_err
	localparam int BIT_CEB = 18; // resp_end_bit_err, highest flag
	localparam int BIT_SUM = 15; // error_summary, read only
	localparam int BIT_CMD_CRC_CHECK_EN = 19; // cmd_crc_check_en in host_command_reg
	localparam int IDX_CTO = 0; // flag index inside err
	localparam int IDX_RESP_CRC_ERR = 1;
	localparam int IDX_CEB = 2;
	localparam int LANE_ERR = 2; // byte lane holding bits 23:16

	// ------------------------------------------------------------
	// link framing and timing
	// ------------------------------------------------------------
	localparam logic [7:0] RESP_SHORT_BITS = 8'h30; // 48 bit response
	localparam logic [7:0] RESP_LONG_BITS = 8'h88; // 136 bit response
	localparam logic [7:0] LONG_HDR_BITS = 8'h08; // header outside crc on long frames
	localparam logic [7:0] CRC_TRAIL_BITS = 8'h08; // crc7 plus end bit
	localparam logic [7:0] FIRST_BIT = 8'h01; // index of the start bit
	localparam logic [6:0] CRC7_POLY = 7'h09; // x^7 + x^3 + 1
	localparam logic [6:0] TIMEOUT_CYCLES = 7'h40; // 64 interface clock cycles

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SCERR_RX_IDLE, SCERR_RX_WAIT, SCERR_RX_RECV} scerr_rx_state_t;

	typedef struct packed {
		logic awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic wvalid;
		logic [AXI_DW-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_AW-1:0] araddr;
		logic rready;
	} scerr_axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [AXI_DW-1:0] rdata;
		logic [1:0] rresp;
	} scerr_axi_rsp_t;

	typedef struct packed {
		logic sent; // pulse: end bit of a command left the host
		logic resp_long; // the awaited response is 136 bits
	} scerr_cmd_issue_t;

	typedef struct packed {
		logic rise; // pulse: interface clock rose
		logic bit_val; // command line level at that rise
	} scerr_link_t;

	typedef struct packed {
		logic clk_meta;
		logic clk_sync;
		logic clk_prev;
		logic cmd_meta;
		logic cmd_sync;
		scerr_link_t out;
	} scerr_smp_state_t;

endpackage : scerr_pkg

// ---- rtl/scerr_link_sampler.sv ----
module scerr_link_sampler
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sd_clk_pin,
	input wire logic sd_cmd_pin,
	output scerr_pkg::scerr_link_t link
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	scerr_pkg::scerr_smp_state_t st; // registered copy
	scerr_pkg::scerr_smp_state_t next_st; // next copy

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// the meta stages feed only the sync stages; edges are found one stage later
	always_comb
	begin
		next_st = st;
		next_st.clk_meta = sd_clk_pin;
		next_st.clk_sync = st.clk_meta;
		next_st.clk_prev = st.clk_sync;
		next_st.cmd_meta = sd_cmd_pin;
		next_st.cmd_sync = st.cmd_meta;
		// clock and line share the same delay, so the level is taken at the edge
		next_st.out.rise = st.clk_sync & ~st.clk_prev;
		next_st.out.bit_val = st.cmd_sync;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// idle line reads high after reset so no false start bit appears
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st <= '{clk_meta: 1'b0, clk_sync: 1'b0, clk_prev: 1'b0, cmd_meta: 1'b1, cmd_sync: 1'b1,
				out: '{rise: 1'b0, bit_val: 1'b1}};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign link = st.out;

endmodule : scerr_link_sampler

// ---- rtl/scerr_status_regs.sv ----
// Functional notes
// [R01] end bit zero sets resp_end_bit_err
// [R02] crc7 mismatch sets resp_crc_err when enabled
// [R03] no start within 64 clocks: timeout
// [R04] timeout declared only at cycle 64
// [R05] error_summary is or of bits 31:16
// [R06] error_summary ignores software writes
// [R07] write one clears flag, zero keeps
// [R08] flags stay set until cleared or reset
module scerr_status_regs
#(
	parameter logic [6:0] TO_CYCLES = scerr_pkg::TIMEOUT_CYCLES
)
(
	input wire logic clock,
	input wire logic rst_n,
	input scerr_pkg::scerr_axi_req_t axi_req,
	output scerr_pkg::scerr_axi_rsp_t axi_rsp,
	input scerr_pkg::scerr_cmd_issue_t cmd_issue,
	input wire logic sd_clk_pin,
	input wire logic sd_cmd_pin,
	output logic irq
);

	// ------------------------------------------------------------
	// state of the block
	// ------------------------------------------------------------
	typedef struct packed {
		scerr_pkg::scerr_rx_state_t rx; // response receiver
		logic [6:0] to_cnt; // interface clocks waited
		logic [7:0] bit_idx; // last received bit index
		logic long_resp; // frame length selector
		logic [6:0] crc_calc; // running crc7
		logic [6:0] crc_rx; // received crc7
		logic [31:0] shift; // payload shift register
		logic [31:0] resp_word; // last completed payload word
		logic [scerr_pkg::ERR_FLAGS-1:0] err; // sticky error flags
		logic [scerr_pkg::ERR_FLAGS-1:0] mask; // interrupt mask
		logic crc_en; // cmd_crc_check_en
		logic irq; // interrupt line
		logic aw_have; // write address held
		logic w_have; // write data held
		logic [scerr_pkg::AXI_AW-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		scerr_pkg::scerr_axi_rsp_t rsp; // registered bus outputs
	} scerr_state_t;

	localparam logic [6:0] TO_LAST = 7'(TO_CYCLES - 7'h01); // last counted clock

	scerr_state_t st; // registered copy
	scerr_state_t next_st; // next copy
	scerr_pkg::scerr_link_t link; // sampled link events
	logic ev_ceb; // end bit error event
	logic ev_resp_crc_err; // crc error event
	logic ev_cto; // timeout event
	logic ev_ok; // clean response event
	logic wr_fire; // write executes this cycle
	logic wr_status; // that write hits the status register
	logic [scerr_pkg::ERR_FLAGS-1:0] clr; // write-one-to-clear mask
	logic [7:0] idx; // index of the bit now arriving

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// word compare, byte offset bits ignored
	function automatic logic is_reg(input logic [scerr_pkg::AXI_AW-1:0] a, input logic [scerr_pkg::AXI_AW-1:0] off);
		is_reg = (a[scerr_pkg::AXI_AW-1:2] == off[scerr_pkg::AXI_AW-1:2]);
	endfunction : is_reg

	// total bits in a response frame
	function automatic logic [7:0] frame_len(input logic long_f);
		frame_len = long_f ? scerr_pkg::RESP_LONG_BITS : scerr_pkg::RESP_SHORT_BITS;
	endfunction : frame_len

	// bit belongs to the crc-covered region
	function automatic logic in_data(input logic [7:0] i, input logic long_f);
		logic [7:0] first;
		first = long_f ? 8'(scerr_pkg::LONG_HDR_BITS + scerr_pkg::FIRST_BIT) : scerr_pkg::FIRST_BIT;
		in_data = (i >= first) && (i <= 8'(frame_len(long_f) - scerr_pkg::CRC_TRAIL_BITS));
	endfunction : in_data

	// one serial step of crc7
	function automatic logic [6:0] crc7_step(input logic [6:0] c, input logic b);
		logic fb;
		fb = b ^ c[6];
		crc7_step = {c[5:0], 1'b0} ^ (fb ? scerr_pkg::CRC7_POLY : 7'h00);
	endfunction : crc7_step

	// status word as software sees it
	function automatic logic [31:0] status_word(input logic [scerr_pkg::ERR_FLAGS-1:0] e);
		status_word = 32'h0;
		status_word[scerr_pkg::BIT_CEB:scerr_pkg::BIT_CTO] = e;
		status_word[scerr_pkg::BIT_SUM] = |status_word[31:16]; // [R05]
	endfunction : status_word

	// ------------------------------------------------------------
	// link sampling
	// ------------------------------------------------------------
	scerr_link_sampler u_sampler
	(
		.clock(clock),
		.rst_n(rst_n),
		.sd_clk_pin(sd_clk_pin),
		.sd_cmd_pin(sd_cmd_pin),
		.link(link)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		ev_ceb = 1'b0;
		ev_resp_crc_err = 1'b0;
		ev_cto = 1'b0;
		ev_ok = 1'b0;
		clr = '0;
		idx = 8'(st.bit_idx + 8'h01);
		wr_fire = st.aw_have && st.w_have && !st.rsp.bvalid;
		wr_status = wr_fire && is_reg(st.aw_addr, scerr_pkg::OFF_STATUS);

		// response receiver on interface clock edges
		case (st.rx)
			scerr_pkg::SCERR_RX_IDLE:
			begin
				// a new command only counts once the previous one is done
				if (cmd_issue.sent)
				begin
					next_st.rx = scerr_pkg::SCERR_RX_WAIT;
					next_st.to_cnt = 7'h00;
					next_st.long_resp = cmd_issue.resp_long;
				end
			end
			scerr_pkg::SCERR_RX_WAIT:
			begin
				if (link.rise && !link.bit_val)
				begin
					// start bit inside the window
					next_st.rx = scerr_pkg::SCERR_RX_RECV;
					next_st.bit_idx = scerr_pkg::FIRST_BIT;
					next_st.crc_calc = in_data(scerr_pkg::FIRST_BIT, st.long_resp) ? crc7_step(7'h00, 1'b0) : 7'h00;
					next_st.crc_rx = 7'h00;
				end
				else if (link.rise && (st.to_cnt == TO_LAST))
				begin
					// a start bit ends the wait early; only the last counted rise times out
					ev_cto = 1'b1; // [R03] [R04]
					next_st.rx = scerr_pkg::SCERR_RX_IDLE;
				end
				else if (link.rise)
				begin
					next_st.to_cnt = 7'(st.to_cnt + 7'h01); // [R04]
				end
			end
			scerr_pkg::SCERR_RX_RECV:
			begin
				if (link.rise)
				begin
					next_st.bit_idx = idx;
					if (in_data(idx, st.long_resp))
					begin
						// covered bits feed crc and payload
						next_st.crc_calc = crc7_step(st.crc_calc, link.bit_val);
						next_st.shift = {st.shift[30:0], link.bit_val};
					end
					else if (idx < frame_len(st.long_resp))
					begin
						// header bits of a long frame shift harmlessly here too
						next_st.crc_rx = {st.crc_rx[5:0], link.bit_val};
					end
					else
					begin
						// end bit position
						ev_ceb = !link.bit_val; // [R01]
						ev_resp_crc_err = st.crc_en && (st.crc_calc != st.crc_rx); // [R02]
						ev_ok = link.bit_val && !ev_resp_crc_err;
						next_st.resp_word = st.shift;
						next_st.rx = scerr_pkg::SCERR_RX_IDLE;
					end
				end
			end
			default:
			begin
				next_st.rx = scerr_pkg::SCERR_RX_IDLE;
			end
		endcase

		// write address and data, taken in either order
		if (axi_req.awvalid && st.rsp.awready)
		begin
			next_st.aw_have = 1'b1;
			next_st.aw_addr = axi_req.awaddr;
		end
		if (axi_req.wvalid && st.rsp.wready)
		begin
			next_st.w_have = 1'b1;
			next_st.w_data = axi_req.wdata;
			next_st.w_strb = axi_req.wstrb;
		end
		if (st.rsp.bvalid && axi_req.bready)
		begin
			next_st.rsp.bvalid = 1'b0;
		end

		// write execution once both halves are held
		if (wr_fire)
		begin
			next_st.aw_have = 1'b0;
			next_st.w_have = 1'b0;
			next_st.rsp.bvalid = 1'b1;
			next_st.rsp.bresp = scerr_pkg::RESP_OKAY;
			if (wr_status)
			begin
				// the summary bit has no storage, so writing it does nothing
				clr = st.w_strb[scerr_pkg::LANE_ERR] ? st.w_data[scerr_pkg::BIT_CEB:scerr_pkg::BIT_CTO] : '0; // [R07] [R06]
			end
			else if (is_reg(st.aw_addr, scerr_pkg::OFF_MASK))
			begin
				if (st.w_strb[scerr_pkg::LANE_ERR])
				begin
					next_st.mask = st.w_data[scerr_pkg::BIT_CEB:scerr_pkg::BIT_CTO];
				end
			end
			else if (is_reg(st.aw_addr, scerr_pkg::OFF_CMD))
			begin
				if (st.w_strb[scerr_pkg::LANE_ERR])
				begin
					next_st.crc_en = st.w_data[scerr_pkg::BIT_CMD_CRC_CHECK_EN];
				end
			end
			else if (!is_reg(st.aw_addr, scerr_pkg::OFF_RESP))
			begin
				// unmapped write answers SLVERR; the read-only response word accepts and drops writes
				next_st.rsp.bresp = scerr_pkg::RESP_SLVERR;
			end
		end

		// sticky flags: a new event beats a clear in the same cycle
		next_st.err = (st.err & ~clr) | {ev_ceb, ev_resp_crc_err, ev_cto}; // [R08] [R07]
		next_st.irq = |(next_st.err & next_st.mask);

		// read channel
		if (st.rsp.rvalid && axi_req.rready)
		begin
			next_st.rsp.rvalid = 1'b0;
		end
		if (axi_req.arvalid && st.rsp.arready)
		begin
			next_st.rsp.rvalid = 1'b1;
			next_st.rsp.rresp = scerr_pkg::RESP_OKAY;
			if (is_reg(axi_req.araddr, scerr_pkg::OFF_STATUS))
			begin
				next_st.rsp.rdata = status_word(st.err); // [R05]
			end
			else if (is_reg(axi_req.araddr, scerr_pkg::OFF_MASK))
			begin
				next_st.rsp.rdata = status_word('0);
				next_st.rsp.rdata[scerr_pkg::BIT_CEB:scerr_pkg::BIT_CTO] = st.mask;
			end
			else if (is_reg(axi_req.araddr, scerr_pkg::OFF_CMD))
			begin
				next_st.rsp.rdata = 32'h0;
				next_st.rsp.rdata[scerr_pkg::BIT_CMD_CRC_CHECK_EN] = st.crc_en;
			end
			else if (is_reg(axi_req.araddr, scerr_pkg::OFF_RESP))
			begin
				next_st.rsp.rdata = st.resp_word;
			end
			else
			begin
				next_st.rsp.rdata = 32'h0;
				next_st.rsp.rresp = scerr_pkg::RESP_SLVERR;
			end
		end

		// readies follow from what is held, so they are plain flops
		next_st.rsp.awready = !next_st.aw_have && !next_st.rsp.bvalid;
		next_st.rsp.wready = !next_st.w_have && !next_st.rsp.bvalid;
		next_st.rsp.arready = !next_st.rsp.rvalid;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// all-zero reset: receiver idle, flags clear, readies low for one cycle
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign axi_rsp = st.rsp;
	assign irq = st.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	chk_end_bit_set: assert property (ev_ceb |=> st.err[scerr_pkg::IDX_CEB]) // [R01]
		else $error("end bit error not flagged");

	chk_end_bit_cause: assert property ($rose(st.err[scerr_pkg::IDX_CEB]) |->
		$past(st.rx == scerr_pkg::SCERR_RX_RECV && link.rise && !link.bit_val)) // [R01]
		else $error("end bit flag set without zero end bit");

	chk_crc_gate: assert property ($rose(st.err[scerr_pkg::IDX_RESP_CRC_ERR]) |-> $past(st.crc_en)) // [R02]
		else $error("crc flag set while check disabled");

	chk_crc_mismatch: assert property ((st.rx == scerr_pkg::SCERR_RX_RECV && link.rise && st.crc_en
		&& st.bit_idx == 8'(frame_len(st.long_resp) - 8'h01) && st.crc_calc != st.crc_rx)
		|=> st.err[scerr_pkg::IDX_RESP_CRC_ERR]) // [R02]
		else $error("crc mismatch not flagged");

	chk_timeout_point: assert property ($rose(st.err[scerr_pkg::IDX_CTO]) |->
		($past(st.to_cnt) == TO_LAST && $past(st.rx) == scerr_pkg::SCERR_RX_WAIT)) // [R03]
		else $error("timeout flagged at wrong count");

	chk_no_early_to: assert property ((st.rx == scerr_pkg::SCERR_RX_WAIT && st.to_cnt != TO_LAST)
		|=> !$rose(st.err[scerr_pkg::IDX_CTO])) // [R04]
		else $error("timeout flagged before window end");

	chk_start_in_time: assert property ((st.rx == scerr_pkg::SCERR_RX_WAIT && link.rise && !link.bit_val)
		|=> st.rx == scerr_pkg::SCERR_RX_RECV && !$rose(st.err[scerr_pkg::IDX_CTO])) // [R03]
		else $error("start bit inside window not accepted");

	chk_summary_read: assert property ((axi_req.arvalid && st.rsp.arready
		&& is_reg(axi_req.araddr, scerr_pkg::OFF_STATUS))
		|=> st.rsp.rdata[scerr_pkg::BIT_SUM] == $past(|st.err)) // [R05]
		else $error("summary bit does not match flags");

	chk_summary_ro: assert property ((wr_status && st.w_data[scerr_pkg::BIT_CEB:scerr_pkg::BIT_CTO] == '0)
		|=> ($past(st.err) & ~st.err) == '0) // [R06]
		else $error("write to summary bit changed flags");

	chk_w1c_clear: assert property ((wr_status && st.w_strb[scerr_pkg::LANE_ERR]
		&& st.w_data[scerr_pkg::BIT_CEB] && !ev_ceb) |=> !st.err[scerr_pkg::IDX_CEB]) // [R07]
		else $error("write one did not clear flag");

	chk_w0_keep: assert property ((wr_status && !st.w_data[scerr_pkg::BIT_CTO] && st.err[scerr_pkg::IDX_CTO])
		|=> st.err[scerr_pkg::IDX_CTO]) // [R07]
		else $error("write zero changed flag");

	chk_flag_sticky: assert property ((st.err != '0 && !wr_status)
		|=> (st.err & $past(st.err)) == $past(st.err)) // [R08]
		else $error("flag dropped without software clear");

	cov_timeout: cover property ($rose(st.err[scerr_pkg::IDX_CTO]));
	cov_crc_err: cover property ($rose(st.err[scerr_pkg::IDX_RESP_CRC_ERR]));
	cov_end_err: cover property ($rose(st.err[scerr_pkg::IDX_CEB]));
	cov_clean_resp: cover property (ev_ok ##1 st.rx == scerr_pkg::SCERR_RX_IDLE);
	cov_long_resp: cover property (ev_ok && st.long_resp);

endmodule : scerr_status_regs

// ---- tb/scerr_card_model.sv ----
// ------------------------------------------------------------
// card side of the command line
// ------------------------------------------------------------
module scerr_card_model
(
	output logic sd_clk,
	output logic sd_cmd
);
	timeunit 1ns;
	timeprecision 100ps;

	// clock stands still low between ticks, line rests on its pull-up
	initial
	begin
		sd_clk = 1'b0;
		sd_cmd = 1'b1;
	end

	// one bit: line changes while clock is low, host samples the rise
	task automatic tick(input logic b);
		sd_cmd = b;
		#62.5 sd_clk = 1'b1;
		#62.5 sd_clk = 1'b0;
	endtask : tick

	// clock rises with the line released high, no start bit
	task automatic idle(input int n);
		repeat (n) tick(1'b1);
	endtask : idle

	// n body bits from bit n-1 down, crc7 msb first; the first hdr bits stay outside the crc
	task automatic send(input int gap, input logic [127:0] body, input int n, input int hdr,
		input logic bad_crc, input logic end_bit);
		logic [6:0] crc;
		crc = 7'h00;
		for (int i = n - 1 - hdr; i >= 0; i--)
			crc = {crc[5:0], 1'b0} ^ ((body[i] ^ crc[6]) ? 7'h09 : 7'h00);
		crc[0] = crc[0] ^ bad_crc;
		idle(gap);
		for (int i = n - 1; i >= 0; i--)
			tick(body[i]);
		for (int i = 6; i >= 0; i--)
			tick(crc[i]);
		tick(end_bit);
		sd_cmd = 1'b1; // released: pull-up level
	endtask : send

	// short response after gap idle rises; crc covers start, direction, index, argument
	task automatic respond(input int gap, input logic [5:0] idx, input logic [31:0] arg,
		input logic bad_crc, input logic end_bit);
		send(gap, {88'h0, 2'h0, idx, arg}, 40, 0, bad_crc, end_bit);
	endtask : respond

	// long response: start, direction, six ones, then 120 crc-covered bits
	task automatic respond_long(input int gap, input logic [119:0] payload,
		input logic bad_crc, input logic end_bit);
		send(gap, {8'h3F, payload}, 128, 8, bad_crc, end_bit);
	endtask : respond_long

endmodule : scerr_card_model

// ---- tb/scerr_status_regs_bench.sv ----
module scerr_status_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;

	logic clock;
	logic rst_n;
	scerr_pkg::scerr_axi_req_t axi_req;
	scerr_pkg::scerr_axi_rsp_t axi_rsp;
	scerr_pkg::scerr_cmd_issue_t cmd_issue;
	logic sd_clk;
	logic sd_cmd;
	logic irq;
	int n_mismatch; // failed comparisons
	int checks; // all comparisons
	logic [31:0] rd; // last read word
	logic [1:0] rr; // last response code

	scerr_status_regs DUT (.clock(clock), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
		.cmd_issue(cmd_issue), .sd_clk_pin(sd_clk), .sd_cmd_pin(sd_cmd), .irq(irq));

	scerr_card_model card (.sd_clk(sd_clk), .sd_cmd(sd_cmd));

	// 125 MHz system clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// ------------------------------------------------------------
	// report and compare
	// ------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	// ------------------------------------------------------------
	// bus master; bready and rready stay high throughout
	// ------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		bit ad;
		bit wd;
		bit bd;
		n = 0;
		ad = 0;
		wd = 0;
		bd = 0;
		@(posedge clock);
		axi_req.awvalid <= 1'b1;
		axi_req.awaddr <= a;
		axi_req.wvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		// each channel released at its own take, either order
		while (!bd && n < 200)
		begin
			@(posedge clock);
			n++;
			if (ad && wd && axi_rsp.bvalid)
			begin
				bd = 1;
				rr = axi_rsp.bresp;
			end
			if (!ad && axi_rsp.awready)
			begin
				ad = 1;
				axi_req.awvalid <= 1'b0;
			end
			if (!wd && axi_rsp.wready)
			begin
				wd = 1;
				axi_req.wvalid <= 1'b0;
			end
		end
		if (!bd)
		begin
			cmp("write answer", 32'h1, 32'h0);
			end_of_test();
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int n;
		bit ad;
		bit dd;
		n = 0;
		ad = 0;
		dd = 0;
		@(posedge clock);
		axi_req.arvalid <= 1'b1;
		axi_req.araddr <= a;
		while (!dd && n < 200)
		begin
			@(posedge clock);
			n++;
			if (ad && axi_rsp.rvalid)
			begin
				dd = 1;
				rd = axi_rsp.rdata;
				rr = axi_rsp.rresp;
			end
			if (!ad && axi_rsp.arready)
			begin
				ad = 1;
				axi_req.arvalid <= 1'b0;
			end
		end
		if (!dd)
		begin
			cmp("read answer", 32'h1, 32'h0);
			end_of_test();
		end
	endtask : axi_rd

	task automatic stat(input logic [31:0] e, input logic ei);
		axi_rd(scerr_pkg::OFF_STATUS);
		cmp("status", e, rd);
		cmp("irq", {31'h0, ei}, {31'h0, irq});
	endtask : stat

	// one-cycle pulse: command end bit just left the host; lg selects the long frame
	task automatic issue_len(input logic lg);
		@(posedge clock);
		cmd_issue.sent <= 1'b1;
		cmd_issue.resp_long <= lg;
		@(posedge clock);
		cmd_issue.sent <= 1'b0;
		cmd_issue.resp_long <= 1'b0;
	endtask : issue_len

	task automatic issue;
		issue_len(1'b0);
	endtask : issue

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		stat(32'h0, 1'b0);
		axi_rd(8'h10);
		cmp("unmapped rresp", {30'h0, scerr_pkg::RESP_SLVERR}, {30'h0, rr});
		axi_wr(8'h10, 32'hFFFF_FFFF);
		cmp("unmapped bresp", {30'h0, scerr_pkg::RESP_SLVERR}, {30'h0, rr});
		stat(32'h0, 1'b0);
	endtask : t_reset

	task automatic t_end_bit;
		axi_wr(scerr_pkg::OFF_MASK, 32'h0007_0000);
		issue();
		card.respond(2, 6'h11, 32'h1234_5678, 1'b0, 1'b0);
		stat(32'h0004_8000, 1'b1);
		axi_wr(scerr_pkg::OFF_STATUS, 32'h0000_8000);
		stat(32'h0004_8000, 1'b1);
		axi_wr(scerr_pkg::OFF_STATUS, 32'h0003_0000);
		stat(32'h0004_8000, 1'b1);
		// a clean response must not wipe the sticky flag
		issue();
		card.respond(2, 6'h11, 32'hA5A5_0F0F, 1'b0, 1'b1);
		stat(32'h0004_8000, 1'b1);
		axi_rd(scerr_pkg::OFF_RESP);
		cmp("payload", 32'hA5A5_0F0F, rd);
		axi_wr(scerr_pkg::OFF_RESP, 32'h0);
		cmp("payload bresp", {30'h0, scerr_pkg::RESP_OKAY}, {30'h0, rr});
		axi_rd(scerr_pkg::OFF_RESP);
		cmp("payload kept", 32'hA5A5_0F0F, rd);
		axi_wr(scerr_pkg::OFF_MASK, 32'h0);
		stat(32'h0004_8000, 1'b0);
		axi_wr(scerr_pkg::OFF_STATUS, 32'h0004_0000);
		stat(32'h0, 1'b0);
	endtask : t_end_bit

	task automatic t_crc;
		axi_wr(scerr_pkg::OFF_MASK, 32'h0007_0000);
		issue();
		card.respond(3, 6'h2A, 32'h0000_0001, 1'b1, 1'b1);
		stat(32'h0, 1'b0);
		axi_wr(scerr_pkg::OFF_CMD, 32'h0008_0000);
		axi_rd(scerr_pkg::OFF_CMD);
		cmp("crc enable", 32'h0008_0000, rd);
		issue();
		card.respond(2, 6'h3F, 32'hFFFF_FFFF, 1'b0, 1'b1);
		stat(32'h0, 1'b0);
		issue();
		card.respond(2, 6'h3F, 32'hFFFF_FFFF, 1'b1, 1'b1);
		stat(32'h0002_8000, 1'b1);
		axi_wr(scerr_pkg::OFF_STATUS, 32'h0002_0000);
		stat(32'h0, 1'b0);
		// long frame: header bits stay outside the crc
		issue_len(1'b1);
		card.respond_long(2, {3{40'h12_3456_789A}}, 1'b0, 1'b1);
		stat(32'h0, 1'b0);
		axi_rd(scerr_pkg::OFF_RESP);
		cmp("long payload", 32'h3456_789A, rd);
		issue_len(1'b1);
		card.respond_long(2, {3{40'h12_3456_789A}}, 1'b1, 1'b1);
		stat(32'h0002_8000, 1'b1);
		axi_wr(scerr_pkg::OFF_STATUS, 32'h0002_0000);
		stat(32'h0, 1'b0);
	endtask : t_crc

	task automatic t_timeout;
		issue();
		card.idle(63);
		stat(32'h0, 1'b0);
		card.idle(1);
		stat(32'h0001_8000, 1'b1);
		// zeros on the timeout bit leave it standing
		axi_wr(scerr_pkg::OFF_STATUS, 32'h0006_0000);
		stat(32'h0001_8000, 1'b1);
		axi_wr(scerr_pkg::OFF_STATUS, 32'h0001_0000);
		stat(32'h0, 1'b0);
		// late start bit still inside the window
		issue();
		card.respond(62, 6'h05, 32'h0BAD_F00D, 1'b0, 1'b1);
		stat(32'h0, 1'b0);
	endtask : t_timeout

	// a mid-run reset wipes flags, mask and crc enable
	task automatic t_reset_mid;
		issue();
		card.idle(64);
		stat(32'h0001_8000, 1'b1);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		stat(32'h0, 1'b0);
		axi_rd(scerr_pkg::OFF_MASK);
		cmp("mask after reset", 32'h0, rd);
		axi_rd(scerr_pkg::OFF_CMD);
		cmp("crc enable after reset", 32'h0, rd);
	endtask : t_reset_mid

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		n_mismatch = 0;
		checks = 0;
		rst_n = 1'b0;
		axi_req = '0;
		axi_req.bready = 1'b1;
		axi_req.rready = 1'b1;
		cmd_issue = '0;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_end_bit();
		t_crc();
		t_timeout();
		t_reset_mid();
		end_of_test();
	end

endmodule : scerr_status_regs_bench
